// *** per_params.svh ***
// Purpose: constants of the protection event reporter
// Assumes: included by its bare name
// Notes:   offsets are byte addresses of the controller registers
`ifndef PER_PARAMS_SVH
`define PER_PARAMS_SVH
// ----------------------------------------
// mask reset values
// ----------------------------------------
`define PER_PHASE_MASK_RST 8'h55
`define PER_EARTH_MASK_RST 8'h55
`define PER_OUT_MASK_RST   11'h300
// ----------------------------------------
// event codes
// ----------------------------------------
`define PER_CODE_NONE      6'h00
`define PER_CODE_FIRST_OUT 6'h11
`define PER_CODE_RESTART   6'h32
`define PER_CODE_OVERFLOW  6'h33
`define PER_CTRL_CLEAR     11'h000
// ----------------------------------------
// controller register offsets and fields
// ----------------------------------------
`define PER_OFS_PHASE   5'h00
`define PER_OFS_EARTH   5'h04
`define PER_OFS_OUT     5'h08
`define PER_OFS_CTRL    5'h0C
`define PER_OFS_EVENT   5'h10
`define PER_OFS_ISTAT   5'h14
`define PER_OFS_IMASK   5'h18
`define PER_EVT_VALID   8
`define PER_IRQ_EVENT   0
`define PER_IRQ_OVF     1
`define PER_RESP_OKAY   2'h0
`define PER_RESP_SLVERR 2'h2
`endif

// *** per_pkg.sv ***
// Purpose: shared types of the protection event reporter
// Assumes: nothing
// Notes:   constants live in per_params.svh
package per_pkg;
  // link request kinds
  typedef enum logic [2:0]
  {
    PER_REQ_NONE  = 3'h0,
    PER_REQ_PHASE = 3'h1,
    PER_REQ_EARTH = 3'h2,
    PER_REQ_OUT   = 3'h3,
    PER_REQ_CTRL  = 3'h4,
    PER_REQ_READ  = 3'h5
  } per_kind_e;
  typedef logic [5:0]  per_code_t;
  typedef logic [10:0] per_word_t;
  // host poll state, gray along idle -> wait
  typedef enum logic [0:0]
  {
    PER_POLL_IDLE = 1'h0,
    PER_POLL_WAIT = 1'h1
  } per_poll_e;
endpackage

// *** per_link_if.sv ***
// Purpose: serial-bus stand-in between communicator and relay module
// Assumes: one clock shared by both ends
// Notes:   requests are one-cycle pulses, reads answered next cycle
`timescale 1ns/1ps
interface per_link_if;
  logic              req_valid;
  per_pkg::per_kind_e req_kind;
  per_pkg::per_word_t req_data;
  logic              rsp_valid;
  per_pkg::per_code_t rsp_code;
  modport dev
  (
    input  req_valid,
    input  req_kind,
    input  req_data,
    output rsp_valid,
    output rsp_code
  );
  modport host
  (
    output req_valid,
    output req_kind,
    output req_data,
    input  rsp_valid,
    input  rsp_code
  );
endinterface

// *** per_fifo.sv ***
// Purpose: small first-in first-out store of event codes
// Assumes: push ignored when full unless popped in the same cycle
// Notes:   depth must be a power of two
`timescale 1ns/1ps
module per_fifo #(
  parameter int WIDTH = 6,
  parameter int DEPTH = 8
)(
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic             push,
  input  wire logic [WIDTH-1:0] push_data,
  input  wire logic             pop,
  output logic      [WIDTH-1:0] pop_data,
  output logic                  full,
  output logic                  empty
);
  localparam int PW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0]               rd;
    logic [PW-1:0]               wr;
    logic [PW:0]                 cnt;
  } per_fifo_s;
  per_fifo_s q;
  per_fifo_s next_q;
  logic      do_push;
  logic      do_pop;

  // ----------------------------------------
  // parameter check
  // ----------------------------------------
  if (DEPTH < 2 || (1 << PW) != DEPTH)
  begin : g_bad
    $error("per_fifo depth must be a power of two");
  end

  // ----------------------------------------
  // pointer and count update
  // ----------------------------------------
  always_comb
  begin
    next_q  = q;
    do_pop  = pop && q.cnt != '0;
    do_push = push && (q.cnt != (PW+1)'(DEPTH) || do_pop);
    if (do_push)
    begin
      next_q.mem[q.wr] = push_data;
      next_q.wr        = q.wr + 1'b1;
    end
    if (do_pop)
    begin
      next_q.rd = q.rd + 1'b1;
    end
    next_q.cnt = q.cnt + (PW+1)'(do_push) - (PW+1)'(do_pop);
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      q <= '0;
    end
    else
    begin
      q <= next_q;
    end
  end

  // oldest entry always visible at the head
  assign pop_data = q.mem[q.rd];
  assign full     = q.cnt == (PW+1)'(DEPTH);
  assign empty    = q.cnt == '0;
endmodule

// *** per_relay.sv ***
// Purpose: event reporting end of the protection relay module
// Assumes: stage and output levels synchronous to CLK
// Notes:   events are queued in a small buffer for the communicator
//
// Operation
// (RULE_01) each event E1-E16 masked by remote words
// (RULE_02) mask bit n weights event n, set reports
// (RULE_03) phase and earth masks take 0 to 255
// (RULE_04) both stage masks reset to 85
// (RULE_05) ten-bit mask gates output events E17-E26
// (RULE_06) output mask takes values 0 to 1024
// (RULE_07) output mask resets to 768
// (RULE_08) system events E50-E54 never masked
// (RULE_09) enabled events wait in eight-entry buffer
// (RULE_10) ninth event on full buffer raises E51
// (RULE_11) overflow stays until remote writes zero control
// (RULE_12) four events per stage: start/trip assert/release
// (RULE_13) output events alternate activate, release per output
// (RULE_14) overflow event has no mask weight
// (RULE_15) E52-E54 come only from the communicator
// (RULE_16) delivery oldest first, delivered entry freed
// (RULE_17) masked events dropped before buffering
`timescale 1ns/1ps
`include "per_params.svh"
module per_relay #(
  parameter int STAGES  = 4,
  parameter int OUTS    = 5,
  parameter int BUF_LEN = 8
)(
  input  wire logic              CLK,
  input  wire logic              RESET,
  per_link_if.dev                LINK,
  input  wire logic [STAGES-1:0] STAGE_START,
  input  wire logic [STAGES-1:0] STAGE_TRIP,
  input  wire logic [OUTS-1:0]   OUT_SIGNAL,
  output logic                   OVERFLOW
);
  localparam int NEV = 4 * STAGES + 2 * OUTS;

  typedef struct packed {
    logic [STAGES-1:0]   start_prev;
    logic [STAGES-1:0]   trip_prev;
    logic [OUTS-1:0]     out_prev;
    logic [NEV-1:0]      pending;
    logic                restart;
    logic                ovf;
    logic                ovf_told;
    logic [7:0]          phase_mask;
    logic [7:0]          earth_mask;
    per_pkg::per_word_t  out_mask;
    logic                rsp_valid;
    per_pkg::per_code_t  rsp_code;
  } per_relay_s;

  per_relay_s         q;
  per_relay_s         next_q;
  logic [NEV-1:0]     raw;
  logic [NEV-1:0]     enable;
  logic               push;
  per_pkg::per_code_t push_code;
  logic               pop;
  per_pkg::per_code_t head;
  logic               full;
  logic               empty;

  // ----------------------------------------
  // parameter check
  // ----------------------------------------
  if (STAGES != 4 || OUTS != 5)
  begin : g_bad
    $error("per_relay mask layout serves four stages and five outputs");
  end

  // ----------------------------------------
  // edge detection, one event per edge
  // ----------------------------------------
  for (genvar s = 0; s < STAGES; s++)
  begin : g_stage
    assign raw[4*s]   = STAGE_START[s] & ~q.start_prev[s]; // RULE_12
    assign raw[4*s+1] = ~STAGE_START[s] & q.start_prev[s]; // RULE_12
    assign raw[4*s+2] = STAGE_TRIP[s] & ~q.trip_prev[s];   // RULE_12
    assign raw[4*s+3] = ~STAGE_TRIP[s] & q.trip_prev[s];   // RULE_12
  end
  for (genvar k = 0; k < OUTS; k++)
  begin : g_out
    assign raw[4*STAGES+2*k]   = OUT_SIGNAL[k] & ~q.out_prev[k]; // RULE_13
    assign raw[4*STAGES+2*k+1] = ~OUT_SIGNAL[k] & q.out_prev[k]; // RULE_13
  end

  // mask bit i weights event i+1 within its word; bit 10 of out mask unused
  assign enable = {q.out_mask[9:0], q.earth_mask, q.phase_mask}; // RULE_01 RULE_02 RULE_05

  // ----------------------------------------
  // event buffer
  // ----------------------------------------
  per_fifo #(
    .WIDTH ($bits(per_pkg::per_code_t)),
    .DEPTH (BUF_LEN)
  ) u_buf (
    .clk       (CLK),
    .rst       (RESET),
    .push      (push),
    .push_data (push_code),
    .pop       (pop),
    .pop_data  (head),
    .full      (full),
    .empty     (empty)
  );

  // ----------------------------------------
  // capture, enqueue, answer and mask writes
  // ----------------------------------------
  always_comb
  begin
    logic found;
    next_q           = q;
    found            = 1'b0;
    push             = 1'b0;
    push_code        = `PER_CODE_NONE;
    pop              = 1'b0;
    next_q.start_prev = STAGE_START;
    next_q.trip_prev  = STAGE_TRIP;
    next_q.out_prev   = OUT_SIGNAL;
    // masked events never reach the pending set
    next_q.pending   = q.pending | (raw & enable); // RULE_17
    // one event a cycle into the buffer, restart first
    if (q.restart)
    begin
      push           = 1'b1;
      push_code      = `PER_CODE_RESTART; // RULE_08
      next_q.restart = 1'b0;
    end
    else
    begin
      for (int i = 0; i < NEV; i++)
      begin
        if (!found && q.pending[i])
        begin
          found             = 1'b1;
          push              = 1'b1;
          push_code         = 6'(i + 1);
          next_q.pending[i] = 1'b0 | (raw[i] & enable[i]);
        end
      end
    end
    // answer a read with the oldest entry
    next_q.rsp_valid = 1'b0;
    next_q.rsp_code  = `PER_CODE_NONE;
    if (LINK.req_valid && LINK.req_kind == per_pkg::PER_REQ_READ)
    begin
      next_q.rsp_valid = 1'b1;
      if (!empty)
      begin
        pop             = 1'b1; // RULE_16
        next_q.rsp_code = head; // RULE_16
      end
      else if (q.ovf && !q.ovf_told)
      begin
        next_q.rsp_code = `PER_CODE_OVERFLOW; // RULE_14
        next_q.ovf_told = 1'b1;
      end
    end
    // remote writes of masks and control
    if (LINK.req_valid)
    begin
      unique case (LINK.req_kind)
        per_pkg::PER_REQ_PHASE: next_q.phase_mask = LINK.req_data[7:0]; // RULE_03
        per_pkg::PER_REQ_EARTH: next_q.earth_mask = LINK.req_data[7:0]; // RULE_03
        per_pkg::PER_REQ_OUT:   next_q.out_mask   = LINK.req_data;      // RULE_06
        per_pkg::PER_REQ_CTRL:
        begin
          if (LINK.req_data == `PER_CTRL_CLEAR)
          begin
            next_q.ovf      = 1'b0; // RULE_11
            next_q.ovf_told = 1'b0;
          end
        end
        default:
        begin
          next_q.ovf = next_q.ovf;
        end
      endcase
    end
    // full buffer with no pop loses the event; set wins over clear
    if (push && full && !pop)
    begin
      next_q.ovf      = 1'b1; // RULE_09 RULE_10
      next_q.ovf_told = 1'b0;
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      q            <= '0;
      q.restart    <= 1'b1;                // RULE_08
      q.phase_mask <= `PER_PHASE_MASK_RST; // RULE_04
      q.earth_mask <= `PER_EARTH_MASK_RST; // RULE_04
      q.out_mask   <= `PER_OUT_MASK_RST;   // RULE_07
    end
    else
    begin
      q <= next_q;
    end
  end

  // responses and overflow come straight from flops
  assign OVERFLOW       = q.ovf; // RULE_11
  assign LINK.rsp_valid = q.rsp_valid;
  assign LINK.rsp_code  = q.rsp_code;
endmodule

// *** per_comm.sv ***
// Purpose: communicator end, polls the relay and serves software
// Assumes: AXI4-Lite master, one read and one write at a time
// Notes:   a read of the event register consumes the held event
//
// Decided for this implementation: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`include "per_params.svh"
module per_comm (
  input  wire logic        CLK,
  input  wire logic        RESET,
  per_link_if.host         LINK,
  input  wire logic [4:0]  AWADDR,
  input  wire logic        AWVALID,
  output logic             AWREADY,
  input  wire logic [31:0] WDATA,
  input  wire logic        WVALID,
  output logic             WREADY,
  output logic [1:0]       BRESP,
  output logic             BVALID,
  input  wire logic        BREADY,
  input  wire logic [4:0]  ARADDR,
  input  wire logic        ARVALID,
  output logic             ARREADY,
  output logic [31:0]      RDATA,
  output logic [1:0]       RRESP,
  output logic             RVALID,
  input  wire logic        RREADY,
  output logic             IRQ
);
  typedef struct packed {
    logic               awready;
    logic               wready;
    logic [4:0]         waddr;
    logic [31:0]        wdata;
    logic [1:0]         bresp;
    logic               bvalid;
    logic               arready;
    logic [31:0]        rdata;
    logic [1:0]         rresp;
    logic               rvalid;
    per_pkg::per_poll_e poll;
    logic               ev_valid;
    per_pkg::per_code_t ev_code;
    logic [1:0]         istat;
    logic [1:0]         imask;
    logic               irq;
    logic               req_valid;
    per_pkg::per_kind_e req_kind;
    per_pkg::per_word_t req_data;
  } per_comm_s;
  per_comm_s q;
  per_comm_s next_q;

  // ----------------------------------------
  // bus slave, link master and poller
  // ----------------------------------------
  always_comb
  begin
    next_q           = q;
    next_q.req_valid = 1'b0;
    next_q.req_kind  = per_pkg::PER_REQ_NONE;
    // take address and data in either order
    if (AWVALID && q.awready)
    begin
      next_q.awready = 1'b0;
      next_q.waddr   = AWADDR;
    end
    if (WVALID && q.wready)
    begin
      next_q.wready = 1'b0;
      next_q.wdata  = WDATA;
    end
    if (BVALID && BREADY)
    begin
      next_q.bvalid  = 1'b0;
      next_q.awready = 1'b1;
      next_q.wready  = 1'b1;
    end
    // both halves held: act and answer
    if (!q.awready && !q.wready && !q.bvalid)
    begin
      next_q.bvalid = 1'b1;
      next_q.bresp  = `PER_RESP_OKAY;
      next_q.req_data = q.wdata[10:0];
      unique case (q.waddr)
        `PER_OFS_PHASE: next_q.req_kind = per_pkg::PER_REQ_PHASE; // RULE_01 RULE_03
        `PER_OFS_EARTH: next_q.req_kind = per_pkg::PER_REQ_EARTH; // RULE_01 RULE_03
        `PER_OFS_OUT:   next_q.req_kind = per_pkg::PER_REQ_OUT;   // RULE_06
        `PER_OFS_CTRL:  next_q.req_kind = per_pkg::PER_REQ_CTRL;  // RULE_11
        `PER_OFS_ISTAT: next_q.istat = q.istat & ~q.wdata[1:0];
        `PER_OFS_IMASK: next_q.imask = q.wdata[1:0];
        `PER_OFS_EVENT: next_q.bresp = `PER_RESP_OKAY;
        default:        next_q.bresp = `PER_RESP_SLVERR;
      endcase
      next_q.req_valid = next_q.req_kind != per_pkg::PER_REQ_NONE;
    end
    // reads; the event register hands over its event
    if (RVALID && RREADY)
    begin
      next_q.rvalid  = 1'b0;
      next_q.arready = 1'b1;
    end
    if (ARVALID && q.arready)
    begin
      next_q.arready = 1'b0;
      next_q.rvalid  = 1'b1;
      next_q.rresp   = `PER_RESP_OKAY;
      next_q.rdata   = 32'h0000_0000;
      unique case (ARADDR)
        `PER_OFS_EVENT:
        begin
          next_q.rdata = {23'h0, q.ev_valid, 2'h0, q.ev_code};
          next_q.ev_valid = 1'b0;
        end
        `PER_OFS_ISTAT: next_q.rdata = {30'h0, q.istat};
        `PER_OFS_IMASK: next_q.rdata = {30'h0, q.imask};
        `PER_OFS_PHASE,
        `PER_OFS_EARTH,
        `PER_OFS_OUT,
        `PER_OFS_CTRL:  next_q.rresp = `PER_RESP_OKAY;
        default:        next_q.rresp = `PER_RESP_SLVERR;
      endcase
    end
    // poll only while the event holder is free; writes go first
    unique case (q.poll)
      per_pkg::PER_POLL_IDLE:
      begin
        if (!next_q.req_valid && !next_q.ev_valid)
        begin
          next_q.req_valid = 1'b1;
          next_q.req_kind  = per_pkg::PER_REQ_READ;
          next_q.poll      = per_pkg::PER_POLL_WAIT;
        end
      end
      per_pkg::PER_POLL_WAIT:
      begin
        if (LINK.rsp_valid)
        begin
          next_q.poll = per_pkg::PER_POLL_IDLE;
          if (LINK.rsp_code != `PER_CODE_NONE)
          begin
            next_q.ev_valid = 1'b1;
            next_q.ev_code  = LINK.rsp_code;
            next_q.istat[`PER_IRQ_EVENT] = 1'b1;
          end
          if (LINK.rsp_code == `PER_CODE_OVERFLOW)
          begin
            next_q.istat[`PER_IRQ_OVF] = 1'b1;
          end
        end
      end
    endcase
    next_q.irq = |(next_q.istat & next_q.imask);
  end

  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      q         <= '0;
      q.awready <= 1'b1;
      q.wready  <= 1'b1;
      q.arready <= 1'b1;
    end
    else
    begin
      q <= next_q;
    end
  end

  // every output straight from its flop
  assign AWREADY        = q.awready;
  assign WREADY         = q.wready;
  assign BRESP          = q.bresp;
  assign BVALID         = q.bvalid;
  assign ARREADY        = q.arready;
  assign RDATA          = q.rdata;
  assign RRESP          = q.rresp;
  assign RVALID         = q.rvalid;
  assign IRQ            = q.irq;
  assign LINK.req_valid = q.req_valid;
  assign LINK.req_kind  = q.req_kind;
  assign LINK.req_data  = q.req_data;
endmodule

// *** per_link_properties.sv ***
// Purpose: link checks between communicator and relay
// Assumes: one clock, RESET asynchronous and active high
// Notes:   watches link signals and the overflow flag only
`timescale 1ns/1ps
module per_link_properties (
  input wire logic               CLK,
  input wire logic               RESET,
  input wire logic               req_valid,
  input wire per_pkg::per_kind_e req_kind,
  input wire per_pkg::per_word_t req_data,
  input wire logic               rsp_valid,
  input wire per_pkg::per_code_t rsp_code,
  input wire logic               OVERFLOW
);
  logic read_req;
  logic clear_req;
  // decoded requests, plain signals so $past sees no expressions
  assign read_req  = req_valid && req_kind == per_pkg::PER_REQ_READ;
  assign clear_req = req_valid && req_kind == per_pkg::PER_REQ_CTRL && req_data == 11'h000;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);
  // ----------------------------------------
  // link timing and content
  // ----------------------------------------
  read_answer_a:
    assert property (read_req |=> rsp_valid) else $error("read not answered next cycle");
  answer_cause_a:
    assert property (rsp_valid |-> $past(read_req)) else $error("answer without a read");
  read_spacing_a:
    assert property (read_req |=> !read_req) else $error("second read while one pending");
  code_range_a:
    assert property (rsp_valid |-> rsp_code <= 6'h1A || rsp_code == 6'h32 || rsp_code == 6'h33)
      else $error("answer code outside the relay set");
  kind_legal_a:
    assert property (req_valid |-> req_kind inside {[per_pkg::PER_REQ_PHASE:per_pkg::PER_REQ_READ]})
      else $error("request of unknown kind");
  stage_mask_range_a:
    assert property (req_valid && req_kind inside {per_pkg::PER_REQ_PHASE, per_pkg::PER_REQ_EARTH}
      |-> req_data[10:8] == 3'h0) else $error("stage mask above 255");
  out_mask_range_a:
    assert property (req_valid && req_kind == per_pkg::PER_REQ_OUT |-> req_data <= 11'h400)
      else $error("output mask above 1024");
  ovf_sticky_a:
    assert property (OVERFLOW && !clear_req |=> OVERFLOW) else $error("overflow dropped by itself");
  ovf_report_a:
    assert property (rsp_valid && rsp_code == 6'h33 |-> OVERFLOW) else $error("overflow code unheld");
endmodule

// *** protection_event_reporter_tb.sv ***
// Purpose: end-to-end bench of relay and communicator
// Assumes: software side is AXI4-Lite, one access at a time
// Notes:   drivers queue expected answers, a monitor compares them
`timescale 1ns/1ps
`include "per_params.svh"
module protection_event_reporter_tb;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic        clk, reset, irq, ovf;
  logic [3:0]  st_start, st_trip;
  logic [4:0]  out_sig, awaddr, araddr;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata, r;
  logic [1:0]  bresp, rresp;
  logic [25:0] cur_mask;
  logic [34:0] note;
  logic [34:0] exp_r[$];
  logic [1:0]  exp_b[$];
  int          bad_count, comparisons, seed, i;
  per_link_if  link ();
  per_relay per_relay_inst (.CLK(clk), .RESET(reset), .LINK(link), .STAGE_START(st_start),
    .STAGE_TRIP(st_trip), .OUT_SIGNAL(out_sig), .OVERFLOW(ovf));
  per_comm per_comm_inst (.CLK(clk), .RESET(reset), .LINK(link), .AWADDR(awaddr),
    .AWVALID(awvalid), .AWREADY(awready), .WDATA(wdata), .WVALID(wvalid), .WREADY(wready),
    .BRESP(bresp), .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
    .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
    .IRQ(irq));
  per_link_properties per_link_properties_inst (.CLK(clk), .RESET(reset),
    .req_valid(link.req_valid), .req_kind(link.req_kind), .req_data(link.req_data),
    .rsp_valid(link.rsp_valid), .rsp_code(link.rsp_code), .OVERFLOW(ovf));
  // 100 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // ----------------------------------------
  // reporting
  // ----------------------------------------
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic give_up();
    bad_count++;
    $display("CHECK FAILED wait expected answer seen timeout");
    test_done();
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // ----------------------------------------
  // bus master, ready is held up from the start
  // ----------------------------------------
  task automatic axi_write(input logic [4:0] a, input logic [31:0] d, input logic [1:0] rs);
    int n;
    exp_b.push_back(rs);
    @(posedge clk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (n = 0; n < 100; n++)
    begin
      @(posedge clk);
      if (bvalid)
        break;
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end
    bready <= 1'b0;
    if (n == 100)
      give_up();
  endtask
  task automatic axi_read(input logic [4:0] a, input logic [31:0] d, input logic [2:0] rs);
    int n;
    exp_r.push_back({rs, d});
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (n = 0; n < 100; n++)
    begin
      @(posedge clk);
      if (rvalid)
        break;
      if (arready)
        arvalid <= 1'b0;
    end
    rready <= 1'b0;
    if (n == 100)
      give_up();
  endtask
  // answers are compared in order against the driver's notes
  always @(posedge clk)
  begin
    if (bvalid && bready)
      check("write resp", {30'h0, exp_b.pop_front()}, {30'h0, bresp});
    if (rvalid && rready && exp_r.size() > 0)
    begin
      note = exp_r.pop_front();
      check("read resp", {30'h0, note[33:32]}, {30'h0, rresp});
      if (note[34])
        check("read data", note[31:0], rdata);
    end
  end
  // ----------------------------------------
  // event helpers
  // ----------------------------------------
  // status is cleared before the read, so a later arrival sets it again
  task automatic get_event(input int code);
    int n;
    for (n = 0; n < 60 && irq !== 1'b1; n++)
      @(posedge clk);
    if (n == 60)
      give_up();
    axi_write(`PER_OFS_ISTAT, 32'h3, `PER_RESP_OKAY);
    axi_read(`PER_OFS_EVENT, 32'h100 | code, {1'b1, `PER_RESP_OKAY});
  endtask
  task automatic quiet();
    tick(20);
    check("irq idle", 32'h0, {31'h0, irq});
  endtask
  task automatic set_masks(input logic [7:0] p, input logic [7:0] e, input logic [10:0] o);
    axi_write(`PER_OFS_PHASE, {24'h0, p}, `PER_RESP_OKAY);
    axi_write(`PER_OFS_EARTH, {24'h0, e}, `PER_RESP_OKAY);
    axi_write(`PER_OFS_OUT, {21'h0, o}, `PER_RESP_OKAY);
    cur_mask = {o[9:0], e, p};
  endtask
  // new levels, then every enabled edge is read back in code order
  task automatic step(input logic [3:0] s, input logic [3:0] t, input logic [4:0] o);
    logic [25:0] ev;
    int j;
    for (j = 0; j < 4; j++)
    begin
      ev[4*j]   = s[j] & ~st_start[j];
      ev[4*j+1] = ~s[j] & st_start[j];
      ev[4*j+2] = t[j] & ~st_trip[j];
      ev[4*j+3] = ~t[j] & st_trip[j];
    end
    for (j = 0; j < 5; j++)
    begin
      ev[16+2*j] = o[j] & ~out_sig[j];
      ev[17+2*j] = ~o[j] & out_sig[j];
    end
    ev = ev & cur_mask;
    @(posedge clk);
    st_start <= s;
    st_trip  <= t;
    out_sig  <= o;
    for (j = 0; j < 26; j++)
      if (ev[j])
        get_event(j + 1);
    quiet();
  endtask
  task automatic do_reset();
    @(posedge clk);
    reset    <= 1'b1;
    st_start <= 4'h0;
    st_trip  <= 4'h0;
    out_sig  <= 5'h00;
    tick(16);
    reset    <= 1'b0;
    cur_mask = {10'h300, 8'h55, 8'h55};
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    seed = 32'h0216;
    reset = 1'b1;
    {st_start, st_trip, out_sig, awaddr, araddr, wdata} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    do_reset();
    check("overflow idle", 32'h0, {31'h0, ovf});
    // masked interrupt stays low although the restart event waits
    axi_write(`PER_OFS_IMASK, 32'h0, `PER_RESP_OKAY);
    tick(3);
    check("irq masked", 32'h0, {31'h0, irq});
    axi_write(`PER_OFS_IMASK, 32'h3, `PER_RESP_OKAY);
    axi_read(`PER_OFS_IMASK, 32'h3, {1'b1, `PER_RESP_OKAY});
    get_event(50);
    step(4'hF, 4'hF, 5'h1F);
    step(4'h0, 4'h0, 5'h00);
    axi_write(5'h1C, 32'h1, `PER_RESP_SLVERR);
    axi_read(5'h1C, 32'h0, {1'b0, `PER_RESP_SLVERR});
    // boundary masks first, then random masks and levels
    for (i = 0; i < 24; i++)
    begin
      r = $random(seed);
      if (i == 0)
        set_masks(8'h00, 8'h00, 11'h400);
      else if (i == 1)
        set_masks(8'hFF, 8'hFF, 11'h3FF);
      else
        set_masks(r[7:0], r[15:8], 11'(r[31:16] % 1025));
      r = $random(seed);
      if (r[31])
        step(r[3:0], r[7:4], out_sig);
      else
        step(st_start, st_trip, r[12:8]);
    end
    // overflow: one held, eight stored, the rest dropped
    set_masks(8'h00, 8'h00, 11'h000);
    step(4'h0, 4'h0, 5'h00);
    set_masks(8'hFF, 8'hFF, 11'h000);
    st_start <= 4'hF;
    st_trip  <= 4'hF;
    tick(20);
    st_start <= 4'h0;
    st_trip  <= 4'h0;
    tick(20);
    check("overflow set", 32'h1, {31'h0, ovf});
    for (i = 0; i < 8; i++)
      get_event(2 * i + 1);
    get_event(2);
    get_event(51);
    quiet();
    axi_write(`PER_OFS_CTRL, 32'h5, `PER_RESP_OKAY);
    tick(3);
    check("overflow held", 32'h1, {31'h0, ovf});
    axi_write(`PER_OFS_CTRL, 32'h0, `PER_RESP_OKAY);
    tick(3);
    check("overflow cleared", 32'h0, {31'h0, ovf});
    // second reset in mid-run restarts the reporting
    do_reset();
    axi_write(`PER_OFS_IMASK, 32'h3, `PER_RESP_OKAY);
    get_event(50);
    test_done();
  end
endmodule
